// file: verilog/mmtc_regs.vh
// mmtc_regs.vh: constants for the multi-mode timer (modes, fields, reset values)
// assumes: included by bare name from the timer design files
`ifndef MMTC_REGS_VH
`define MMTC_REGS_VH
// mode codes, {extension bit, 3-bit mode field}
`define MMTC_MODE_ONESHOT 4'h0
`define MMTC_MODE_CONT 4'h1
`define MMTC_MODE_COUNTER 4'h2
`define MMTC_MODE_PWM1 4'h3
`define MMTC_MODE_CAPT 4'h4
`define MMTC_MODE_CMP 4'h5
`define MMTC_MODE_GATED 4'h6
`define MMTC_MODE_CAPCMP 4'h7
`define MMTC_MODE_PWM2 4'h8
`define MMTC_MODE_CAPRST 4'h9
// interrupt source select field codes
`define MMTC_IRQ_BOTH0 2'h0
`define MMTC_IRQ_BOTH1 2'h1
`define MMTC_IRQ_CAPT 2'h2
`define MMTC_IRQ_RELOAD 2'h3
// counter values
`define MMTC_CNT_RESTART 16'h0001
`define MMTC_CNT_ZERO 16'h0000
`define MMTC_CNT_MAX 16'hFFFF
// prescale field width and dead time field width
`define MMTC_PRES_W 3
`define MMTC_DT_W 3
`endif

// file: verilog/mmtc_prescaler.v
// mmtc_prescaler.v: divides the system clock into a one-cycle tick enable
// assumes: one clock, synchronous active-high reset; divide is 2^pres_i
`timescale 1ns/1ps
`include "mmtc_regs.vh"
module mmtc_prescaler (
    input wire mclk_i,
    input wire srst_i,
    input wire run_i,
    input wire [`MMTC_PRES_W-1:0] pres_i,
    output wire tick_o
);
    reg [6:0] div_q; // free divider, cleared while stopped
    wire [7:0] lim; // 2^pres_i
    assign lim = 8'h01 << pres_i;
    // tick when the divider reaches its last count
    assign tick_o = run_i && (div_q == (lim[6:0] - 7'h01));
    // divider: restarts when timer stops so first tick is a full period
    always @(posedge mclk_i) begin
        if (srst_i || !run_i || tick_o) begin
            div_q <= 7'h00;
        end else begin
            div_q <= div_q + 7'h01;
        end
    end
endmodule // mmtc_prescaler

// file: verilog/mmtc_timer.v
// mmtc_timer.v: 16-bit multi-mode timer with capture, compare, gated and PWM
// assumes: timer input synchronous to mclk_i; software loads count/reload/pwm
// How it works
// - capture-restart reload: count 0001H, clear flag
// - mode is extension bit plus mode field
// - interrupt source: both, capture only, reload only
// - compare match interrupts, counting continues unreset
// - compare match toggles output when enabled
// - compare count wraps FFFFH to 0000H
// - pwm1 polarity 0: idle low, match high
// - pwm1 polarity 1: idle high, match low
// - capture edge: polarity 0 rising, 1 falling
// - compare output idles at polarity, flips on match
// - gated counts on input level, irq end
// - capture/compare starts first edge, captures later
// - pwm2 polarity 0: output/complement swap on match
// - pwm2 polarity 1: inverted pair swap on match
// - dead time delays active level on pwm2
`timescale 1ns/1ps
`include "mmtc_regs.vh"
module mmtc_timer (
    input wire mclk_i,
    input wire srst_i,
    input wire timer_enable_i, // timer_control_first enable bit
    input wire timer_mode_extension_bit_i, // from timer_control_first
    input wire [2:0] timer_mode_field_i, // from timer_control_second
    input wire polarity_i, // polarity / edge bit
    input wire [`MMTC_PRES_W-1:0] prescale_i, // divide by 2^n
    input wire [1:0] interrupt_source_select_i,
    input wire [`MMTC_DT_W-1:0] dead_time_delay_field_i,
    input wire out_alt_en_i, // timer output alternate function enabled
    input wire cnt_wr_i, // software write of the count
    input wire [15:0] cnt_wdata_i,
    input wire [15:0] reload_i, // reload / compare value
    input wire pwm_wr_i, // software write of pwm value
    input wire [15:0] pwm_wdata_i,
    input wire timer_in_i, // timer input pin
    output reg [15:0] count_o,
    output reg [15:0] pwm_value_o, // pwm value / captured count
    output reg capture_source_flag_o,
    output reg irq_o, // one-cycle interrupt pulse
    output reg tout_o, // timer output pin
    output reg tout_n_o // timer output complement
);
    wire [3:0] mode; // combined mode code
    wire tick; // prescaled count enable
    reg in_q; // previous timer input
    reg armed_q; // capture/compare has seen first edge
    reg level_q; // pwm logical level before dead time
    reg [`MMTC_DT_W-1:0] dt_q; // dead time counter
    reg en_q; // enable one cycle ago
    reg [15:0] count_d;
    reg tog; // compare-mode output toggle request
    reg irq_cap, irq_rel; // event strobes before the source select
    reg cap_ev, rel_ev, set_hi, set_lo;
    wire rise, fall, sel_edge, other_edge, gate_ok, cnt_en;

    assign mode = {timer_mode_extension_bit_i, timer_mode_field_i};
    assign rise = timer_in_i && !in_q;
    assign fall = !timer_in_i && in_q;
    assign sel_edge = polarity_i ? fall : rise;
    assign other_edge = polarity_i ? rise : fall;
    // gated mode counts only while input sits at the active level
    assign gate_ok = (mode != `MMTC_MODE_GATED) || (timer_in_i != polarity_i);
    // capture/compare waits for the first selected edge before counting
    assign cnt_en = gate_ok && ((mode != `MMTC_MODE_CAPCMP) || armed_q);

    mmtc_prescaler u_pres (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .run_i(timer_enable_i && cnt_en),
        .pres_i(prescale_i),
        .tick_o(tick)
    );

    // next count and event decode
    always @* begin
        count_d = count_o;
        cap_ev = 1'b0;
        rel_ev = 1'b0;
        tog = 1'b0;
        set_hi = 1'b0;
        set_lo = 1'b0;
        irq_cap = 1'b0;
        irq_rel = 1'b0;
        if (timer_enable_i) begin
            // capture events in the capture modes
            if ((mode == `MMTC_MODE_CAPT || mode == `MMTC_MODE_CAPRST) && sel_edge) begin
                cap_ev = 1'b1;
            end
            if (mode == `MMTC_MODE_CAPCMP && armed_q && sel_edge) begin
                cap_ev = 1'b1;
            end
            // gated: interrupt on the edge that ends the counting level
            if (mode == `MMTC_MODE_GATED && other_edge) begin
                irq_rel = 1'b1;
            end
            if (tick) begin
                count_d = count_o + 16'h0001;
                if (count_o == reload_i) begin
                    if (mode == `MMTC_MODE_CMP) begin
                        // keep counting past the match; wrap is natural
                        irq_rel = 1'b1;
                        tog = 1'b1;
                    end else begin
                        count_d = `MMTC_CNT_RESTART;
                        rel_ev = 1'b1;
                        irq_rel = 1'b1;
                    end
                end
                if (count_o == pwm_value_o && (mode == `MMTC_MODE_PWM1 ||
                        mode == `MMTC_MODE_PWM2)) begin
                    set_hi = 1'b1;
                end
                if (rel_ev && (mode == `MMTC_MODE_PWM1 || mode == `MMTC_MODE_PWM2)) begin
                    set_lo = 1'b1;
                    set_hi = 1'b0; // reload wins over a same-tick match
                end
            end
            // capture-restart also restarts counting on capture
            if (cap_ev) begin
                irq_cap = 1'b1;
                if (mode == `MMTC_MODE_CAPRST || mode == `MMTC_MODE_CAPCMP) begin
                    count_d = `MMTC_CNT_RESTART;
                end
            end
        end
        if (cnt_wr_i) begin
            count_d = cnt_wdata_i; // software write overrides
        end
    end

    // counter, capture register, flag and interrupt
    always @(posedge mclk_i) begin
        if (srst_i) begin
            count_o <= `MMTC_CNT_ZERO;
            pwm_value_o <= `MMTC_CNT_ZERO;
            capture_source_flag_o <= 1'b0;
            irq_o <= 1'b0;
            in_q <= 1'b0;
            armed_q <= 1'b0;
            en_q <= 1'b0;
        end else begin
            count_o <= count_d;
            in_q <= timer_in_i;
            en_q <= timer_enable_i;
            // arm on the first selected edge, disarm when stopped
            if (!timer_enable_i || mode != `MMTC_MODE_CAPCMP) begin
                armed_q <= 1'b0;
            end else if (sel_edge) begin
                armed_q <= 1'b1;
            end
            // capture copies count and marks source in the same edge as irq
            if (cap_ev) begin
                pwm_value_o <= count_o;
            end else if (pwm_wr_i) begin
                pwm_value_o <= pwm_wdata_i;
            end
            if (cap_ev) begin
                capture_source_flag_o <= 1'b1;
            end else if (rel_ev) begin
                capture_source_flag_o <= 1'b0;
            end
            // source select gates which event may interrupt
            case (interrupt_source_select_i)
                `MMTC_IRQ_CAPT: irq_o <= irq_cap;
                `MMTC_IRQ_RELOAD: irq_o <= irq_rel;
                default: irq_o <= irq_cap || irq_rel;
            endcase
        end
    end

    // output logic: logical level, dead time, polarity
    always @(posedge mclk_i) begin
        if (srst_i) begin
            level_q <= 1'b0;
            dt_q <= {`MMTC_DT_W{1'b0}};
            tout_o <= 1'b0;
            tout_n_o <= 1'b1;
        end else if (!timer_enable_i) begin
            // idle: output at polarity, complement opposite
            level_q <= 1'b0;
            dt_q <= {`MMTC_DT_W{1'b0}};
            tout_o <= polarity_i;
            tout_n_o <= !polarity_i;
        end else if (mode == `MMTC_MODE_CMP) begin
            // compare: flip on every match when the pin is routed
            if (tog && out_alt_en_i) begin
                tout_o <= !tout_o;
                tout_n_o <= tout_o;
            end
        end else if (mode == `MMTC_MODE_PWM1) begin
            if (set_hi) begin
                tout_o <= !polarity_i;
            end else if (set_lo) begin
                tout_o <= polarity_i;
            end
            tout_n_o <= 1'b1;
        end else if (mode == `MMTC_MODE_PWM2) begin
            // dead time: both pins rest inactive before the new one goes active
            if (set_hi || set_lo) begin
                level_q <= set_hi;
                dt_q <= dead_time_delay_field_i;
                tout_o <= polarity_i;
                tout_n_o <= polarity_i;
                if (dead_time_delay_field_i == {`MMTC_DT_W{1'b0}}) begin
                    tout_o <= set_hi ^ polarity_i;
                    tout_n_o <= !(set_hi ^ polarity_i);
                end
            end else if (dt_q != {`MMTC_DT_W{1'b0}}) begin
                dt_q <= dt_q - 1'b1;
                if (dt_q == 1'b1) begin
                    tout_o <= level_q ^ polarity_i;
                    tout_n_o <= !(level_q ^ polarity_i);
                end
            end else if (!en_q) begin
                tout_o <= polarity_i;
                tout_n_o <= !polarity_i;
            end
        end else begin
            // other modes: complement on reload
            if (rel_ev && out_alt_en_i) begin
                tout_o <= !tout_o;
                tout_n_o <= tout_o;
            end
        end
    end
endmodule // mmtc_timer

// file: test/mmtc_timer_sva.sv
// mmtc_timer_sva.sv: port-level checks of the multi-mode timer
// assumes: bound to mmtc_timer, one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "mmtc_regs.vh"
module mmtc_timer_sva (
    input wire mclk_i,
    input wire srst_i,
    input wire timer_enable_i,
    input wire timer_mode_extension_bit_i,
    input wire [2:0] timer_mode_field_i,
    input wire polarity_i,
    input wire [`MMTC_PRES_W-1:0] prescale_i,
    input wire [1:0] interrupt_source_select_i,
    input wire out_alt_en_i,
    input wire cnt_wr_i,
    input wire [15:0] reload_i,
    input wire timer_in_i,
    input wire [15:0] count_o,
    input wire [15:0] pwm_value_o,
    input wire capture_source_flag_o,
    input wire irq_o,
    input wire tout_o,
    input wire tout_n_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    wire [3:0] mode = {timer_mode_extension_bit_i, timer_mode_field_i}; // decoded mode
    reg en_q; // enable one cycle back, so the prescaler has started
    // only undivided ticks are judged, the divided ones are left to the bench
    always @(posedge mclk_i) en_q <= timer_enable_i;
    wire run = timer_enable_i && en_q && prescale_i == 0 && !cnt_wr_i; // tick each cycle
    wire hit = run && count_o == reload_i; // reload or compare event
    a_hold_off: assert property (!timer_enable_i && !cnt_wr_i |=> $stable(count_o))
        else $error("count moved while disabled");
    a_count_up: assert property (run && mode == `MMTC_MODE_CMP |=>
        count_o - $past(count_o) == 16'h0001) else $error("compare count did not advance");
    a_cmp_match: assert property (hit && mode == `MMTC_MODE_CMP && out_alt_en_i
        && interrupt_source_select_i != `MMTC_IRQ_CAPT |=> irq_o && tout_o != $past(tout_o))
        else $error("compare match without irq or toggle");
    a_restart_one: assert property (hit && mode == `MMTC_MODE_CAPRST && $stable(timer_in_i)
        |=> count_o == `MMTC_CNT_RESTART && !capture_source_flag_o)
        else $error("restart reload wrong");
    a_capt_only: assert property (hit && mode == `MMTC_MODE_CAPRST && $stable(timer_in_i)
        && interrupt_source_select_i == `MMTC_IRQ_CAPT |=> !irq_o) else $error("reload irq");
    a_capt_copy: assert property (timer_enable_i && mode == `MMTC_MODE_CAPT
        && (polarity_i ? $fell(timer_in_i) : $rose(timer_in_i))
        |=> pwm_value_o == $past(count_o) && capture_source_flag_o) else $error("bad capture");
    a_pwm1_idle: assert property ((!timer_enable_i && mode == `MMTC_MODE_PWM1
        && $stable(polarity_i))[*2] |-> tout_o == polarity_i) else $error("pwm1 idle level");
    a_pwm2_idle: assert property ((!timer_enable_i && mode == `MMTC_MODE_PWM2
        && $stable(polarity_i))[*2] |-> tout_o == polarity_i && tout_n_o != polarity_i)
        else $error("pwm2 idle levels");
    a_cmp_idle: assert property ((!timer_enable_i && mode == `MMTC_MODE_CMP
        && $stable(polarity_i))[*2] |-> tout_o == polarity_i) else $error("compare idle level");
endmodule // mmtc_timer_sva
bind mmtc_timer mmtc_timer_sva i_mmtc_timer_sva (.*);

// file: test/mmtc_pin_model.sv
// mmtc_pin_model.sv: outside source that pulses the timer input pin
// assumes: commanded by the bench; the pin only moves at falling edges
`timescale 1ns/1ps
module mmtc_pin_model (
    input wire mclk_i,
    input wire go_i, // start one high pulse
    input wire [7:0] width_i, // pulse length in cycles
    output wire timer_in_o
);
    reg [7:0] left_q = 8'h00; // cycles of pulse still to drive
    // away from the sampling edge, so the design never sees a half-set pin
    always @(negedge mclk_i) begin
        if (go_i) begin
            left_q <= width_i;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
    end
    assign timer_in_o = (left_q != 8'h00); // driven push-pull, low between pulses
endmodule // mmtc_pin_model

// file: test/test_multi_mode_timer_capture_pwm.sv
// test_multi_mode_timer_capture_pwm.sv: random and corner stimulus for the timer
// assumes: mmtc_timer with its bound checker; inputs move on falling edges
`timescale 1ns/1ps
`include "mmtc_regs.vh"
module test_multi_mode_timer_capture_pwm;
    reg mclk_i = 1'b0, srst_i = 1'b1, en = 1'b0, pol = 1'b0, cwr = 1'b0, pwr = 1'b0, go = 1'b0;
    reg [3:0] mode = 4'h0;
    reg [1:0] sel = 2'h0;
    reg [2:0] pres = 3'h0, dt = 3'h0; // prescale and dead time, set by the tests
    reg [15:0] pwd = 16'h0000; // pwm value loaded by cfg, zero unless a test sets it
    reg [15:0] cdat = 16'h0000, rl = 16'h0000, r, t0;
    wire [15:0] cnt, pv;
    wire flag, irq, to, ton, tin;
    integer n_mismatch, compares, seed, i, k, hits;
    mmtc_timer i_mmtc_timer (.mclk_i(mclk_i), .srst_i(srst_i), .timer_enable_i(en),
        .timer_mode_extension_bit_i(mode[3]), .timer_mode_field_i(mode[2:0]), .polarity_i(pol),
        .prescale_i(pres), .interrupt_source_select_i(sel), .dead_time_delay_field_i(dt),
        .out_alt_en_i(1'b1), .cnt_wr_i(cwr), .cnt_wdata_i(cdat), .reload_i(rl), .pwm_wr_i(pwr),
        .pwm_wdata_i(pwd), .timer_in_i(tin), .count_o(cnt), .pwm_value_o(pv),
        .capture_source_flag_o(flag), .irq_o(irq), .tout_o(to), .tout_n_o(ton));
    mmtc_pin_model i_mmtc_pin_model (.mclk_i(mclk_i), .go_i(go), .width_i(8'h05),
        .timer_in_o(tin));
    initial begin
        forever #10 mclk_i = ~mclk_i;
    end
    // count after a compare match, wrapping past the top
    function [15:0] exp_cmp(input [15:0] v);
        exp_cmp = v + 16'h0001;
    endfunction
    task chk(input [8*8-1:0] nm, input [15:0] ex, input [15:0] got);
        begin
            compares = compares + 1;
            if (got !== ex) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, ex, got);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
            if (n_mismatch == 0 && compares > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // timer off, then mode, edge, start count, reload, pwm value from pwd
    task cfg(input [3:0] m, input p, input [15:0] c, input [15:0] v);
        begin
            en = 1'b0;
            mode = m;
            pol = p;
            cdat = c;
            rl = v;
            cwr = 1'b1;
            pwr = 1'b1;
            @(negedge mclk_i);
            cwr = 1'b0;
            pwr = 1'b0;
            @(negedge mclk_i);
        end
    endtask
    initial begin
        seed = 32'h0232d545;
        n_mismatch = 0;
        compares = 0;
        repeat (8) @(negedge mclk_i);
        srst_i = 1'b0;
        // restart on reload, for every interrupt source choice
        for (i = 0; i < 4; i = i + 1) begin
            sel = i;
            cfg(`MMTC_MODE_CAPRST, 1'b0, `MMTC_CNT_RESTART, 16'h0004);
            en = 1'b1;
            hits = 0;
            repeat (6) begin
                @(negedge mclk_i);
                if (irq === 1'b1) hits = hits + 1;
                if (irq === 1'b1) chk("restart", `MMTC_CNT_RESTART, cnt);
            end
            chk("irqsrc", (sel == `MMTC_IRQ_CAPT) ? 16'h0000 : 16'h0001, hits);
        end
        $display("test restart done");
        // compare matches, top value first, then random
        sel = `MMTC_IRQ_BOTH0;
        for (i = 0; i < 5; i = i + 1) begin
            r = (i == 0) ? `MMTC_CNT_MAX : $random(seed);
            cfg(`MMTC_MODE_CMP, $random(seed), r - 16'h0003, r);
            chk("cmpidle", pol, to);
            t0 = to;
            en = 1'b1;
            for (k = 0; k < 40 && irq !== 1'b1; k = k + 1) @(negedge mclk_i);
            if (k == 40) chk("cmpirq", 16'h0001, irq);
            if (k == 40) wrap_up;
            chk("cmpcnt", exp_cmp(r), cnt);
            chk("cmpout", ~t0 & 16'h0001, to);
        end
        $display("test compare done");
        // idle levels of both pwm modes, both polarities
        for (i = 0; i < 4; i = i + 1) begin
            cfg(i[1] ? `MMTC_MODE_PWM2 : `MMTC_MODE_PWM1, i[0], 16'h0001, 16'h0010);
            chk("pwmidle", pol, to);
            if (i[1]) chk("pwmcomp", ~pol & 1'b1, ton);
        end
        $display("test pwm idle done");
        // dual pwm with two cycles of dead time: match at count 4, reload at 8
        pwd = 16'h0004;
        dt = 3'h2;
        for (i = 0; i < 2; i = i + 1) begin
            cfg(`MMTC_MODE_PWM2, i[0], 16'h0001, 16'h0008);
            en = 1'b1;
            repeat (4) @(negedge mclk_i);
            chk("dtout", pol, to);
            chk("dtcomp", pol, ton);
            repeat (2) @(negedge mclk_i);
            chk("pwmmatch", ~pol & 1'b1, to);
            chk("pwmmcomp", pol, ton);
            repeat (4) @(negedge mclk_i);
            chk("pwmrel", pol, to);
            chk("pwmrcomp", ~pol & 1'b1, ton);
        end
        pwd = 16'h0000;
        dt = 3'h0;
        $display("test pwm dead time done");
        // gated count of a five-cycle high pulse, divided by two
        cfg(`MMTC_MODE_GATED, 1'b0, 16'h0001, `MMTC_CNT_MAX);
        pres = 3'h1;
        en = 1'b1;
        repeat (2) @(negedge mclk_i);
        go <= 1'b1;
        @(negedge mclk_i);
        go <= 1'b0;
        hits = 0;
        repeat (10) begin
            @(negedge mclk_i);
            if (irq === 1'b1) hits = hits + 1;
        end
        chk("gatecnt", 16'h0001 + (16'h0005 >> pres), cnt);
        chk("gateirq", 16'h0001, hits);
        pres = 3'h0;
        $display("test gated done");
        // one pin pulse: only the chosen edge captures
        for (i = 0; i < 2; i = i + 1) begin
            cfg(`MMTC_MODE_CAPT, i[0], 16'h0001, `MMTC_CNT_MAX);
            en = 1'b1;
            repeat (3 + ($random(seed) & 7)) @(negedge mclk_i);
            go <= 1'b1;
            @(negedge mclk_i);
            go <= 1'b0;
            hits = 0;
            repeat (14) begin
                @(negedge mclk_i);
                if (irq === 1'b1) hits = hits + 1;
                if (irq === 1'b1) chk("capval", cnt - 16'h0001, pv);
                if (irq === 1'b1) chk("capflag", 16'h0001, flag);
            end
            chk("capedge", 16'h0001, hits);
        end
        // stopped timer keeps its count
        en = 1'b0;
        r = cnt;
        repeat (5) @(negedge mclk_i);
        chk("hold", r, cnt);
        $display("test capture and hold done");
        wrap_up;
    end
endmodule // test_multi_mode_timer_capture_pwm
